/* File: hw/phy_sb_ctl.sv */
// Purpose: controller end: apb slave issuing management frames
// Assumes: 10 MHz clock; mgmt clock made by divider
// Notes: interrupt pin and data line sampled through two flops
`timescale 1ns/100ps
module phy_sb_ctl (
    input wire logic clk_sys_i,        // system clock
    input wire logic rstn_i,           // async reset
    input wire logic psel,             // apb select
    input wire logic penable,          // apb enable
    input wire logic pwrite,           // apb write
    input wire logic [7:0] paddr,      // apb address
    input wire logic [31:0] pwdata,    // apb write data
    output logic [31:0] prdata,        // apb read data
    output logic pready,               // apb ready
    output logic pslverr,              // apb error
    output logic irq_o,                // level interrupt
    input wire logic irq_active_high_i, // phy pin polarity
    phy_sb_if.ctl pins                 // sideband pins
);
    typedef enum logic [1:0] {C_IDLE, C_SHIFT, C_READ} st_e;
    st_e st_r;
    logic [63:0] sh_r;
    logic [6:0] cnt_r;
    logic [2:0] div_r;
    logic mdc_r, rd_r, busy_r;
    logic [15:0] rdata_r, wdata_r;
    logic [1:0] stat_r, mask_r;
    logic [1:0] irq_s_r;
    logic [1:0] mdio_s_r;
    logic done_evt, acc, wr;
    logic tick_fall;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign tick_fall = (div_r == 3'(phy_sb_pkg::MDC_HALF - 1)) && mdc_r;

    // mgmt clock divider, runs only while a frame is active
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_r <= 3'h0;
            mdc_r <= 1'b0;
        end else if (!busy_r) begin
            div_r <= 3'h0;
            mdc_r <= 1'b0;
        end else if (div_r == 3'(phy_sb_pkg::MDC_HALF - 1)) begin
            div_r <= 3'h0;
            mdc_r <= ~mdc_r;
        end else div_r <= div_r + 3'h1;
    end
    assign pins.mdc = mdc_r;

    // frame engine: data changed on falling edge, read data sampled on falling edge too
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= C_IDLE;
            sh_r <= 64'h0;
            cnt_r <= 7'h00;
            rd_r <= 1'b0;
            busy_r <= 1'b0;
            rdata_r <= 16'h0000;
            pins.mdio_ctl_o <= 1'b1;
            pins.mdio_ctl_oe <= 1'b0;
        end else begin
            unique case (st_r)
                C_IDLE: if (wr && paddr == phy_sb_pkg::APB_CMD &&
                            pwdata[phy_sb_pkg::CMD_GO_BIT]) begin
                    rd_r <= pwdata[phy_sb_pkg::CMD_RD_BIT];
                    sh_r <= {32'hffffffff, 2'h1,
                        pwdata[phy_sb_pkg::CMD_RD_BIT] ?
                        phy_sb_pkg::OP_READ : phy_sb_pkg::OP_WRITE,
                        pwdata[phy_sb_pkg::CMD_ADDR_LSB +: 5],
                        pwdata[phy_sb_pkg::CMD_REG_LSB +: 5],
                        2'h2, wdata_r};
                    cnt_r <= 7'h00;
                    busy_r <= 1'b1;
                    st_r <= C_SHIFT;
                end
                C_SHIFT: if (tick_fall || (cnt_r == 7'h00 && div_r == 3'h0
                                          && !mdc_r)) begin
                    pins.mdio_ctl_oe <= 1'b1;
                    pins.mdio_ctl_o <= sh_r[63];
                    sh_r <= {sh_r[62:0], 1'b1};
                    cnt_r <= cnt_r + 7'h01;
                    if (rd_r && cnt_r == 7'd46) begin
                        // release line for turnaround
                        pins.mdio_ctl_oe <= 1'b0;
                        cnt_r <= 7'h00;
                        st_r <= C_READ;
                    end else if (cnt_r == 7'd64) begin
                        pins.mdio_ctl_oe <= 1'b0;
                        busy_r <= 1'b0;
                        st_r <= C_IDLE;
                    end
                end
                C_READ: if (tick_fall) begin
                    // each slot taken at its closing fall, past the sync
                    cnt_r <= cnt_r + 7'h01;
                    if (cnt_r >= 7'h02)
                        rdata_r <= {rdata_r[14:0], mdio_s_r[1]};
                    if (cnt_r == 7'd17) begin
                        busy_r <= 1'b0;
                        st_r <= C_IDLE;
                    end
                end
                default: st_r <= C_IDLE;
            endcase
        end
    end
    assign done_evt = busy_r && (st_r == C_IDLE ||
        (st_r == C_READ && tick_fall && cnt_r == 7'd17) ||
        (st_r == C_SHIFT && cnt_r == 7'd64 && tick_fall));

    // pin syncs; reset high, so no false event follows reset while irq_active_high_i is low
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_s_r <= 2'h3;
            mdio_s_r <= 2'h3;
        end else begin
            irq_s_r <= {irq_s_r[0], pins.irq_pin};
            mdio_s_r <= {mdio_s_r[0], pins.mdio};
        end
    end

    // status: bit0 done, bit1 phy interrupt; set beats write-one clear
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stat_r <= 2'h0;
            mask_r <= 2'h0;
            wdata_r <= 16'h0000;
            irq_o <= 1'b0;
        end else begin
            stat_r <= (stat_r & ~((wr && paddr == phy_sb_pkg::APB_IRQ_STAT)
                ? pwdata[1:0] : 2'h0))
                | {irq_s_r[1] == irq_active_high_i, done_evt};
            if (wr && paddr == phy_sb_pkg::APB_IRQ_MASK) mask_r <= pwdata[1:0];
            if (wr && paddr == phy_sb_pkg::APB_WDATA) wdata_r <= pwdata[15:0];
            irq_o <= |(stat_r & mask_r);
        end
    end

    // apb answers in the access cycle
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr > phy_sb_pkg::APB_IRQ_MASK;
            unique case (paddr)
                phy_sb_pkg::APB_WDATA: prdata <= {16'h0, wdata_r};
                phy_sb_pkg::APB_RDATA: prdata <= {16'h0, rdata_r};
                phy_sb_pkg::APB_STATUS: prdata <= {31'h0, busy_r};
                phy_sb_pkg::APB_IRQ_STAT: prdata <= {30'h0, stat_r};
                phy_sb_pkg::APB_IRQ_MASK: prdata <= {30'h0, mask_r};
                default: prdata <= 32'h0;
            endcase
        end
    end
endmodule // phy_sb_ctl

/* File: hw/phy_sb_dev.sv */
// Purpose: transceiver end: management slave, interrupt pin, ref clock out
// Assumes: clk_sys_i stands in for the reference input clock
// Notes: mdc and mdio are sampled through two flops, edges found here
// Functional notes
// - management clock comes from the controller
// - data line driven and sampled on mgmt clock
// - interrupt control/status register at 1bh
// - bit 14 of 1fh sets interrupt polarity
// - wake event drives the shared pin low
// - continuous reference clock output to the mac
// - clock pin strap latched as indicator style
// - reset active low, straps latched at release
// - strap pins inputs during reset, outputs after; here they stay inputs only
// - mac must not drive straps during reset
// - system supplies 25 mhz reference input; here clk_sys_i runs at 10 MHz
// - low address bits strapped, upper two zero
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
module phy_sb_dev (
    input wire logic clk_sys_i,     // core clock
    input wire logic rstn_i,        // async reset
    phy_sb_if.dev pins,             // sideband pins
    input wire logic [7:0] irq_evt_i, // interrupt conditions, pulses
    input wire logic wake_evt_i,    // wake-on-lan detected, pulse
    input wire logic wake_mode_i,   // pin acts as wake event output
    output logic indicator_style_o, // latched indicator style
    output logic [4:0] mgmt_addr_o  // latched management address
);
    typedef enum logic [2:0] {S_IDLE, S_HDR, S_TA, S_WR, S_RD} st_e;
    st_e st_r;
    logic [2:0] mdc_s_r, mdio_s_r;
    logic strap_done_r;
    logic [3:0] strap_s1_r, strap_s2_r;
    logic [15:0] irq_cs_r, ctrl_r, sh_r;
    logic [5:0] cnt_r;
    logic [13:0] hdr_r;
    logic wake_r, ref_r, irq_o_r;
    logic mdc_rise, mdc_fall, bit_in;
    logic [4:0] reg_a;

    // two-flop synchronisers, third stage for edge detection
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mdc_s_r <= 3'h0;
            mdio_s_r <= 3'h7;
        end else begin
            mdc_s_r <= {mdc_s_r[1:0], pins.mdc};
            mdio_s_r <= {mdio_s_r[1:0], pins.mdio};
        end
    end
    assign mdc_rise = mdc_s_r[1] & ~mdc_s_r[2];
    assign mdc_fall = ~mdc_s_r[1] & mdc_s_r[2];
    assign bit_in = mdio_s_r[1];
    assign reg_a = hdr_r[4:0];

    // strap pins are board levels: two flops before the latch reads them,
    // no reset so the levels held during reset are what gets latched
    always_ff @(posedge clk_sys_i) begin
        strap_s1_r <= {pins.style_strap, pins.addr_strap};
        strap_s2_r <= strap_s1_r;
    end

    // straps caught on the first edge after reset release
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_done_r <= 1'b0;
            indicator_style_o <= 1'b0;
            mgmt_addr_o <= 5'h00;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            indicator_style_o <= strap_s2_r[3];
            mgmt_addr_o <= {2'h0, strap_s2_r[2:0]};
        end
    end

    // management frame slave
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= S_IDLE;
            cnt_r <= 6'h00;
            hdr_r <= 14'h0000;
            sh_r <= 16'h0000;
            pins.mdio_dev_o <= 1'b1;
            pins.mdio_dev_oe <= 1'b0;
        end else begin
            unique case (st_r)
                S_IDLE: begin
                    pins.mdio_dev_oe <= 1'b0;
                    if (mdc_rise) begin
                        if (bit_in) begin
                            if (cnt_r != 6'h3f) cnt_r <= cnt_r + 6'h01;
                        end else if (cnt_r >= 6'(phy_sb_pkg::PREAMBLE_BITS))
                        begin
                            st_r <= S_HDR;
                            cnt_r <= 6'h00;
                            hdr_r <= 14'h0000;
                        end else cnt_r <= 6'h00;
                    end
                end
                S_HDR: if (mdc_rise) begin
                    // start bit 1, opcode, address, register
                    hdr_r <= {hdr_r[12:0], bit_in};
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == 6'h0c) begin
                        st_r <= S_TA;
                        cnt_r <= 6'h00;
                    end
                end
                S_TA: begin
                    if (hdr_r[12] != 1'b1 ||
                        hdr_r[9:5] != mgmt_addr_o) begin
                        st_r <= S_IDLE;
                        cnt_r <= 6'h00;
                    end else if (hdr_r[11:10] == phy_sb_pkg::OP_READ) begin
                        if (mdc_fall && cnt_r == 6'h00) begin
                            // first turnaround slot stays released
                            cnt_r <= 6'h01;
                        end else if (mdc_fall) begin
                            // second slot driven zero, then data
                            pins.mdio_dev_oe <= 1'b1;
                            pins.mdio_dev_o <= 1'b0;
                            sh_r <= (reg_a == phy_sb_pkg::REG_IRQ_CS) ?
                                irq_cs_r : (reg_a == phy_sb_pkg::REG_PHY_CTRL)
                                ? ctrl_r : 16'h0000;
                            st_r <= S_RD;
                            cnt_r <= 6'h00;
                        end
                    end else if (mdc_rise) begin
                        cnt_r <= cnt_r + 6'h01;
                        if (cnt_r == 6'h01) begin
                            st_r <= S_WR;
                            cnt_r <= 6'h00;
                        end
                    end
                end
                S_WR: if (mdc_rise) begin
                    sh_r <= {sh_r[14:0], bit_in};
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == 6'h0f) begin
                        st_r <= S_IDLE;
                        cnt_r <= 6'h00;
                    end
                end
                S_RD: if (mdc_fall) begin
                    if (cnt_r == 6'h10) begin
                        pins.mdio_dev_oe <= 1'b0;
                        st_r <= S_IDLE;
                        cnt_r <= 6'h00;
                    end else begin
                        pins.mdio_dev_o <= sh_r[15];
                        sh_r <= {sh_r[14:0], 1'b0};
                        cnt_r <= cnt_r + 6'h01;
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // write completion marker: last data bit taken this cycle
    logic wr_done;
    assign wr_done = (st_r == S_WR) && mdc_rise && (cnt_r == 6'h0f);

    // control register with interrupt polarity
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) ctrl_r <= phy_sb_pkg::PHY_CTRL_RESET;
        else if (wr_done && reg_a == phy_sb_pkg::REG_PHY_CTRL)
            ctrl_r <= {sh_r[14:0], bit_in};
    end

    // high byte enables, low byte status; a read clears status,
    // an event in the same cycle still sets its bit
    logic rd_irq;
    assign rd_irq = (st_r == S_TA) && mdc_fall && cnt_r == 6'h01 &&
        hdr_r[12] &&
        hdr_r[9:5] == mgmt_addr_o && hdr_r[11:10] == phy_sb_pkg::OP_READ &&
        reg_a == phy_sb_pkg::REG_IRQ_CS;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) irq_cs_r <= phy_sb_pkg::IRQ_CS_RESET;
        else begin
            if (wr_done && reg_a == phy_sb_pkg::REG_IRQ_CS)
                irq_cs_r[15:8] <= sh_r[14:7];
            irq_cs_r[7:0] <= (rd_irq ? 8'h00 : irq_cs_r[7:0]) | irq_evt_i;
        end
    end

    // wake event latch and interrupt pin
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wake_r <= 1'b0;
            irq_o_r <= 1'b1;
        end else begin
            if (wake_evt_i) wake_r <= 1'b1;
            else if (rd_irq) wake_r <= 1'b0;
            if (wake_mode_i) irq_o_r <= ~wake_r;
            else irq_o_r <= (|(irq_cs_r[15:8] & irq_cs_r[7:0])) ^
                ~ctrl_r[phy_sb_pkg::IRQ_POL_BIT];
        end
    end
    assign pins.irq_pin = irq_o_r;

    // reference clock out, free running after reset
    logic [3:0] ref_cnt_r;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_r <= 1'b0;
            ref_cnt_r <= 4'h0;
        end else if (ref_cnt_r == 4'(phy_sb_pkg::REFCLK_DIV - 1)) begin
            ref_r <= ~ref_r;
            ref_cnt_r <= 4'h0;
        end else begin
            ref_cnt_r <= ref_cnt_r + 4'h1;
        end
    end
    assign pins.ref_clk = ref_r;
endmodule // phy_sb_dev

/* File: hw/phy_sb_if.sv */
// Purpose: pins between controller and transceiver sideband
// Assumes: mdio is pulled up when nobody drives it
// Notes: resolves the shared data line from both enables
`timescale 1ns/100ps
interface phy_sb_if;
    logic mdc;
    logic mdio_ctl_o;
    logic mdio_ctl_oe;
    logic mdio_dev_o;
    logic mdio_dev_oe;
    logic mdio;
    logic irq_pin;
    logic ref_clk;
    logic [2:0] addr_strap;
    logic style_strap;
    logic reset_n;
    assign mdio = (mdio_ctl_oe ? mdio_ctl_o : 1'b1)
                & (mdio_dev_oe ? mdio_dev_o : 1'b1);
    modport ctl (output mdc, output mdio_ctl_o, output mdio_ctl_oe,
                 input mdio, input irq_pin, input ref_clk);
    modport dev (input mdc, output mdio_dev_o, output mdio_dev_oe,
                 input mdio, output irq_pin, output ref_clk,
                 input addr_strap, input style_strap, input reset_n);
endinterface

/* File: hw/phy_sb_pkg.sv */
// Purpose: shared constants for the management sideband link
// Assumes: 10 MHz system clock on both ends
// Notes: management frames follow the usual 32-bit preamble, 2-bit start,
//        2-bit opcode, 5-bit device address, 5-bit register, turnaround
package phy_sb_pkg;
    localparam logic [4:0] REG_IRQ_CS = 5'h1b;
    localparam logic [4:0] REG_PHY_CTRL = 5'h1f;
    localparam int IRQ_POL_BIT = 14;
    localparam logic [15:0] IRQ_CS_RESET = 16'h0000;
    localparam logic [15:0] PHY_CTRL_RESET = 16'h0000;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam int PREAMBLE_BITS = 32;
    // ref clock out: one device-clock toggle per half period
    localparam int REFCLK_DIV = 1;
    // controller divider: mgmt clock half period in system cycles
    localparam int MDC_HALF = 4;
    // apb register offsets of the controller
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_WDATA = 8'h04;
    localparam logic [7:0] APB_RDATA = 8'h08;
    localparam logic [7:0] APB_STATUS = 8'h0c;
    localparam logic [7:0] APB_IRQ_STAT = 8'h10;
    localparam logic [7:0] APB_IRQ_MASK = 8'h14;
    // cmd word fields
    localparam int CMD_REG_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_RD_BIT = 16;
    localparam int CMD_GO_BIT = 31;
endpackage

/* File: verification/phy_sb_props.sv */
// Purpose: assertions on the sideband link between both ends
// Assumes: one clock domain, async active-low reset
// Notes: instantiated beside the interface by the bench
`timescale 1ns/100ps
module phy_sb_props (
    input wire logic clk_sys_i, // system clock
    input wire logic rstn_i, // async reset
    input wire logic mdc, // mgmt clock
    input wire logic mdio_ctl_oe, // controller drives data
    input wire logic mdio_dev_oe, // device drives data
    input wire logic mdio, // resolved data line
    input wire logic irq_pin, // device interrupt pin
    input wire logic ref_clk // clock out to mac
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    logic [1:0] age_r;
    // counts the first edges after reset release
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            age_r <= 2'h0;
        end else if (age_r != 2'h3) begin
            age_r <= age_r + 2'h1;
        end
    end
    sequence s_hold_hi;
        mdc [*4];
    endsequence
    sequence s_hold_lo;
        !mdc [*4];
    endsequence
    a_mdc_high_half: assert property ($rose(mdc) |-> s_hold_hi)
        else $error("mgmt clock high phase too short");
    a_mdc_low_half: assert property ($fell(mdc) |-> s_hold_lo)
        else $error("mgmt clock low phase too short");
    a_mdio_stable_rise: assert property ($rose(mdc) |-> $stable(mdio))
        else $error("data line changed at mgmt clock rise");
    a_no_contention: assert property (mdio_dev_oe |-> !mdio_ctl_oe)
        else $error("both ends drive the data line");
    a_dev_drive_low: assert property ($rose(mdio_dev_oe) |-> !mdc)
        else $error("device started driving outside low phase");
    a_ref_clk_toggle: assert property (age_r == 2'h3 |->
        ref_clk != $past(ref_clk))
        else $error("reference clock out did not toggle");
    a_quiet_after_rst: assert property (age_r != 2'h3 |-> !mdio_dev_oe)
        else $error("device drove data line right after reset");
    a_irq_idle_rst: assert property (age_r == 2'h1 |-> irq_pin)
        else $error("interrupt pin not idle high after reset");
endmodule // phy_sb_props

/* File: verification/tb_phy_mgmt_irq_reset_pins.sv */
// Purpose: drives controller over apb and device sideband inputs
// Assumes: 10 MHz clock, both ends joined by the interface
// Notes: expectations come from register layouts, not from outputs
`timescale 1ns/100ps
module tb_phy_mgmt_irq_reset_pins;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq_o, err, style, pol = 1'b0;
    logic [7:0] irq_evt = 8'h00;
    logic wake_evt = 1'b0, wake_mode = 1'b0;
    logic [4:0] maddr;
    int miscompares = 0, num_checks = 0;
    phy_sb_if sb();
    always #50 clk_sys_i = ~clk_sys_i;
    assign sb.reset_n = rstn_i;
    phy_sb_ctl phy_sb_ctl_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_o(irq_o), .irq_active_high_i(pol),
        .pins(sb));
    phy_sb_dev phy_sb_dev_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .pins(sb), .irq_evt_i(irq_evt), .wake_evt_i(wake_evt),
        .wake_mode_i(wake_mode), .indicator_style_o(style),
        .mgmt_addr_o(maddr));
    phy_sb_props phy_sb_props_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .mdc(sb.mdc), .mdio_ctl_oe(sb.mdio_ctl_oe),
        .mdio_dev_oe(sb.mdio_dev_oe), .mdio(sb.mdio),
        .irq_pin(sb.irq_pin), .ref_clk(sb.ref_clk));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out();
        if (miscompares == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    // one management frame through the controller, result in rd
    task frame(input logic r, input logic [4:0] a, input logic [4:0] g,
               input logic [15:0] d);
        apb(1'b1, phy_sb_pkg::APB_WDATA, {16'h0, d});
        apb(1'b1, phy_sb_pkg::APB_CMD, {1'b1, 14'h0, r, 3'h0, a, 3'h0, g});
        do begin
            apb(1'b0, phy_sb_pkg::APB_STATUS, 32'h0);
        end while (rd[0] !== 1'b0);
        apb(1'b0, phy_sb_pkg::APB_RDATA, 32'h0);
    endtask
    task wait_pin(input logic v);
        int n;
        n = 0;
        while (sb.irq_pin !== v && n < 40) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk({31'h0, sb.irq_pin}, {31'h0, v});
    endtask
    task t_regs();
        apb(1'b0, phy_sb_pkg::APB_IRQ_MASK, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, sb.irq_pin}, 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk({27'h0, maddr}, 32'h5);
        chk({31'h0, style}, 32'h1);
    endtask
    task t_frames();
        frame(1'b0, 5'h05, phy_sb_pkg::REG_IRQ_CS, 16'h0100);
        frame(1'b1, 5'h05, phy_sb_pkg::REG_IRQ_CS, 16'h0);
        chk(rd, 32'h0100);
        frame(1'b1, 5'h03, phy_sb_pkg::REG_IRQ_CS, 16'h0);
        chk(rd, 32'hffff);
    endtask
    task t_irq();
        apb(1'b1, phy_sb_pkg::APB_IRQ_STAT, 32'h3);
        apb(1'b1, phy_sb_pkg::APB_IRQ_MASK, 32'h2);
        irq_evt <= 8'h01;
        @(posedge clk_sys_i);
        irq_evt <= 8'h00;
        wait_pin(1'b0);
        repeat (8) @(posedge clk_sys_i);
        chk({31'h0, irq_o}, 32'h1);
        apb(1'b1, phy_sb_pkg::APB_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk_sys_i);
        chk({31'h0, irq_o}, 32'h0);
        frame(1'b1, 5'h05, phy_sb_pkg::REG_IRQ_CS, 16'h0);
        chk(rd, 32'h0101);
        wait_pin(1'b1);
        repeat (8) @(posedge clk_sys_i);
        apb(1'b1, phy_sb_pkg::APB_IRQ_STAT, 32'h3);
        apb(1'b0, phy_sb_pkg::APB_IRQ_STAT, 32'h0);
        chk(rd, 32'h0);
    endtask
    task t_wake();
        wake_mode <= 1'b1;
        wake_evt <= 1'b1;
        @(posedge clk_sys_i);
        wake_evt <= 1'b0;
        wait_pin(1'b0);
        wake_mode <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task t_pol();
        frame(1'b0, 5'h05, phy_sb_pkg::REG_PHY_CTRL, 16'h4000);
        pol <= 1'b1;
        frame(1'b1, 5'h05, phy_sb_pkg::REG_PHY_CTRL, 16'h0);
        chk(rd, 32'h4000);
        wait_pin(1'b0);
        irq_evt <= 8'h01;
        @(posedge clk_sys_i);
        irq_evt <= 8'h00;
        wait_pin(1'b1);
    endtask
    initial begin
        sb.addr_strap <= 3'h5;
        sb.style_strap <= 1'b1;
        repeat (16) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        sb.addr_strap <= 3'h2;
        sb.style_strap <= 1'b0;
        t_regs();
        t_frames();
        t_irq();
        t_wake();
        t_pol();
        close_out();
    end
    initial begin
        #3000000;
        miscompares++;
        close_out();
    end
endmodule // tb_phy_mgmt_irq_reset_pins
